// [design/fpt_flash_prot.sv]
// Flash protection, timing and byte programming bypass logic
//
// Behaviour
// - Command 5EH while locked opens sector lock
// - Lock bit blocks CPU program/erase per sector
// - Port requests ignore sector lock bits
// - Sector lock bits reset to zero
// - Set lock bits cannot be cleared
// - Small variant uses lower four bits
// - Timing value is high byte, low byte
// - About 30 us program, 10 ms erase
// - Port: cleared protect bits block all or lower half of main
// - Port: info page 3 only, read only protected
// - CPU: no mass erase, no info
// - Bytes 80H F0H 04H enable bypass
// - Bypass stops CPU clock and accesses
// - Bypass drives flash from registered pins
// - Bypass mass erase always permitted
// - Bypass main access limited by protects
// - Bypass info page 3, erase only protected
// - Shared address otherwise writes page select
// - Status shows protect register selected
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module fpt_flash_prot
  import fpt_pkg::*;
#(
  parameter bit WIDE_MEMORY = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_from_port_in,
  output logic [7:0] reg_rdata_out,
  // Option byte protect bits, active low
  input wire logic whole_memory_rw_protect_in,
  input wire logic lower_half_protect_in,
  // Access request
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic req_info_in,
  input wire logic [15:0] req_addr_in,
  input wire logic req_from_port_in,
  output logic grant_out,
  output logic refuse_out,
  // Serial programming port byte stream
  input wire logic port_byte_valid_in,
  input wire logic [7:0] port_byte_in,
  // Bypass pins and flash controls
  input wire logic [7:0] bypass_pins_in,
  output logic [7:0] flash_ctl_out,
  output logic bypass_out,
  output logic cpu_clk_stop_out,
  output logic busy_out,
  output logic flash_prog_out,
  output logic flash_erase_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fpt_st_e st;
    logic [7:0] lock;
    logic [7:0] page;
    logic [7:0] timh;
    logic [7:0] timl;
    logic [7:0] rdata;
    logic [16:0] acc;
    logic [13:0] ticks;
    logic [1:0] byp_step;
    logic bypass;
    logic [7:0] pins;
    logic grant;
    logic refuse;
    logic prog;
    logic erase;
  } fpt_state_s;

  fpt_state_s s_ff;
  fpt_state_s nxt_s;
  logic [15:0] tim_val;
  logic [7:0] lock_used;
  logic ok;
  logic tick;
  logic [16:0] acc_sum;
  fpt_op_e op;

  assign tim_val = {s_ff.timh, s_ff.timl};
  assign lock_used = WIDE_MEMORY ? s_ff.lock : (s_ff.lock & SMALL_MASK);
  assign op = fpt_op_e'(req_op_in);

  // ----------------------------------------------------------------
  // Access permission
  // ----------------------------------------------------------------
  function automatic logic allow(input fpt_op_e o, input logic info,
                                 input logic [15:0] a, input logic port,
                                 input logic byp, input logic rwp_n,
                                 input logic lhp_n, input logic [7:0] lk,
                                 input logic [7:0] pg);
    logic any_prot;
    logic pg3;
    logic lower;
    logic res;
    any_prot = !rwp_n || !lhp_n;
    pg3 = (pg == INFO_PAGE3);
    lower = !a[HALF_BIT];
    res = 1'b0;
    if (byp) begin
      if (o == OP_MERASE) begin
        res = 1'b1;
      end else if (info) begin
        res = pg3 && (!any_prot || o == OP_PERASE);
      end else begin
        res = rwp_n && (lhp_n || !lower);
      end
    end else if (port) begin
      if (o == OP_MERASE) begin
        res = !info;
      end else if (info) begin
        res = pg3 && (o == OP_READ || !any_prot);
      end else begin
        res = rwp_n && (lhp_n || !lower);
      end
    end else begin
      if (info || o == OP_MERASE) begin
        res = 1'b0;
      end else if (o == OP_READ) begin
        res = 1'b1;
      end else begin
        res = !lk[a[SECT_MSB:SECT_LSB]];
      end
    end
    return res;
  endfunction : allow

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.grant = 1'b0;
    nxt_s.refuse = 1'b0;
    nxt_s.rdata = RST_BYTE;
    ok = 1'b0;
    tick = 1'b0;
    acc_sum = s_ff.acc + TICK_STEP;
    // Byte programming bypass enable sequence
    if (port_byte_valid_in && !s_ff.bypass) begin
      unique case (s_ff.byp_step)
        2'h0: nxt_s.byp_step = (port_byte_in == BYP_BYTE0) ? 2'h1 : 2'h0;
        2'h1: nxt_s.byp_step = (port_byte_in == BYP_BYTE1) ? 2'h2 : 2'h0;
        2'h2: begin
          nxt_s.byp_step = 2'h0;
          nxt_s.bypass = (port_byte_in == BYP_BYTE2);
        end
        2'h3: nxt_s.byp_step = 2'h0;
      endcase
    end
    nxt_s.pins = s_ff.bypass ? bypass_pins_in : RST_BYTE;
    // Register reads
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADR_CMD: nxt_s.rdata = {2'h0, s_ff.st};
        ADR_PAGE: nxt_s.rdata = (s_ff.st == ST_SECSEL) ? s_ff.lock : s_ff.page;
        ADR_TIMH: nxt_s.rdata = s_ff.timh;
        ADR_TIML: nxt_s.rdata = s_ff.timl;
        default: nxt_s.rdata = RST_BYTE;
      endcase
    end
    // Register writes and command sequencer
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADR_CMD: begin
          if (s_ff.st == ST_LOCKED && reg_wdata_in == CMD_SECSEL) begin
            nxt_s.st = ST_SECSEL;
          end else if (s_ff.st == ST_LOCKED && reg_wdata_in == CMD_UNLK1) begin
            nxt_s.st = ST_UNLK1;
          end else if (s_ff.st == ST_UNLK1 && reg_wdata_in == CMD_UNLK2) begin
            nxt_s.st = ST_UNLK2;
          end else if (s_ff.st == ST_UNLK2) begin
            nxt_s.st = ST_UNLOCKED;
          end else if (s_ff.st == ST_UNLOCKED && reg_wdata_in == CMD_PERASE) begin
            ok = allow(OP_PERASE, s_ff.page[7], {s_ff.page[6:0], 9'h000},
                       reg_from_port_in, s_ff.bypass,
                       whole_memory_rw_protect_in, lower_half_protect_in,
                       lock_used, s_ff.page);
            nxt_s.st = ok ? ST_PERASE : ST_LOCKED;
          end else if (s_ff.st == ST_UNLOCKED && reg_wdata_in == CMD_MERASE) begin
            ok = allow(OP_MERASE, 1'b0, 16'h0000, reg_from_port_in,
                       s_ff.bypass, whole_memory_rw_protect_in,
                       lower_half_protect_in, lock_used, s_ff.page);
            nxt_s.st = ok ? ST_MERASE : ST_LOCKED;
          end else if (s_ff.st inside {ST_UNLK1, ST_UNLK2, ST_UNLOCKED, ST_SECSEL}) begin
            nxt_s.st = ST_LOCKED;
          end
          if (ok) begin
            nxt_s.ticks = ERASE_TICKS;
            nxt_s.acc = 17'h00000;
          end
        end
        ADR_PAGE: begin
          if (s_ff.st == ST_SECSEL) begin
            nxt_s.lock = s_ff.lock | reg_wdata_in;
            nxt_s.st = ST_LOCKED;
          end else begin
            nxt_s.page = reg_wdata_in;
          end
        end
        ADR_TIMH: nxt_s.timh = reg_wdata_in;
        ADR_TIML: nxt_s.timl = reg_wdata_in;
        default: nxt_s.st = s_ff.st;
      endcase
    end
    // Access requests
    if (req_valid_in) begin
      ok = allow(op, req_info_in, req_addr_in, req_from_port_in, s_ff.bypass,
                 whole_memory_rw_protect_in, lower_half_protect_in,
                 lock_used, s_ff.page);
      if (s_ff.bypass && !req_from_port_in) begin
        ok = 1'b0;
      end
      if (op == OP_PROG && !s_ff.bypass) begin
        ok = ok && s_ff.st == ST_UNLOCKED
             && req_addr_in[SECT_MSB:PAGE_LSB] == s_ff.page[6:0];
      end
      if (op != OP_READ && !s_ff.bypass && op != OP_PROG) begin
        ok = 1'b0;
      end
      nxt_s.grant = ok;
      nxt_s.refuse = !ok;
      if (ok && op == OP_PROG && !s_ff.bypass) begin
        nxt_s.st = ST_PROG;
        nxt_s.ticks = PROG_TICKS;
        nxt_s.acc = 17'h00000;
      end
    end
    // Microsecond tick from timing value
    if (s_ff.st inside {ST_PROG, ST_PERASE, ST_MERASE}) begin
      if (acc_sum >= {1'b0, tim_val}) begin
        tick = 1'b1;
        nxt_s.acc = acc_sum - {1'b0, tim_val};
      end else begin
        nxt_s.acc = acc_sum;
      end
      if (tick) begin
        if (s_ff.ticks <= 14'h0001) begin
          nxt_s.ticks = 14'h0000;
          nxt_s.st = ST_LOCKED;
        end else begin
          nxt_s.ticks = s_ff.ticks - 14'h0001;
        end
      end
    end
    nxt_s.prog = (nxt_s.st == ST_PROG);
    nxt_s.erase = (nxt_s.st inside {ST_PERASE, ST_MERASE});
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata_out = s_ff.rdata;
  assign grant_out = s_ff.grant;
  assign refuse_out = s_ff.refuse;
  assign flash_ctl_out = s_ff.pins;
  assign bypass_out = s_ff.bypass;
  assign cpu_clk_stop_out = s_ff.bypass;
  assign busy_out = s_ff.prog | s_ff.erase;
  assign flash_prog_out = s_ff.prog;
  assign flash_erase_out = s_ff.erase;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  AST_LOCK_STICKY: assert property ((s_ff.lock & $past(s_ff.lock)) == $past(s_ff.lock))
    else $error("sector lock bit cleared");
  AST_LOCK_HOLD: assert property (reg_wr_in && reg_addr_in == ADR_PAGE
    && s_ff.st == ST_SECSEL |=> s_ff.lock == ($past(s_ff.lock) | $past(reg_wdata_in))
    && s_ff.st == ST_LOCKED)
    else $error("sector lock write lost");
  AST_SECSEL: assert property (reg_wr_in && reg_addr_in == ADR_CMD
    && reg_wdata_in == CMD_SECSEL && s_ff.st == ST_LOCKED |=> s_ff.st == ST_SECSEL)
    else $error("protect select not shown");
  AST_PAGE_WR: assert property (reg_wr_in && reg_addr_in == ADR_PAGE
    && s_ff.st != ST_SECSEL |=> $stable(s_ff.lock) && s_ff.page == $past(reg_wdata_in))
    else $error("page write reached lock");
  AST_CPU_MASS: assert property (req_valid_in && !req_from_port_in
    && op == OP_MERASE |=> refuse_out && !grant_out)
    else $error("cpu mass erase granted");
  AST_BYP_MASS: assert property (bypass_out && req_valid_in && req_from_port_in
    && op == OP_MERASE |=> grant_out)
    else $error("bypass mass erase refused");
  AST_BYP_PINS: assert property (bypass_out && $past(bypass_out)
    |-> flash_ctl_out == $past(bypass_pins_in))
    else $error("bypass pins not forwarded");
  AST_PORT_READ: assert property (req_valid_in && req_from_port_in && !bypass_out
    && op == OP_READ && !req_info_in && !whole_memory_rw_protect_in |=> refuse_out)
    else $error("protected port read granted");
  AST_PROG_END: assert property ($rose(flash_prog_out) && tim_val == 16'h03e8
    |-> ##29 flash_prog_out ##1 !flash_prog_out)
    else $error("program duration wrong");

  COV_SECSEL: cover property (s_ff.st == ST_SECSEL ##1 s_ff.lock != 8'h00);
  COV_BYPASS: cover property ($rose(bypass_out));
  COV_ERASE: cover property ($fell(flash_erase_out));

endmodule : fpt_flash_prot

// [shared/fpt_pkg.sv]
// Constants and types of the flash protection and timing block
package fpt_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CMD = 8'h01;
  localparam logic [7:0] ADR_PAGE = 8'h02;
  localparam logic [7:0] ADR_TIMH = 8'h03;
  localparam logic [7:0] ADR_TIML = 8'h04;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // Command codes and bypass enable sequence
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_UNLK1 = 8'h73;
  localparam logic [7:0] CMD_UNLK2 = 8'h8c;
  localparam logic [7:0] CMD_PERASE = 8'h95;
  localparam logic [7:0] CMD_MERASE = 8'h63;
  localparam logic [7:0] CMD_SECSEL = 8'h5e;
  localparam logic [7:0] BYP_BYTE0 = 8'h80;
  localparam logic [7:0] BYP_BYTE1 = 8'hf0;
  localparam logic [7:0] BYP_BYTE2 = 8'h04;
  localparam logic [7:0] INFO_PAGE3 = 8'h83;
  localparam logic [7:0] SMALL_MASK = 8'h0f;
  // ----------------------------------------------------------------
  // Address fields
  // ----------------------------------------------------------------
  localparam int SECT_MSB = 15;
  localparam int SECT_LSB = 13;
  localparam int HALF_BIT = 15;
  localparam int PAGE_LSB = 9;
  // ----------------------------------------------------------------
  // Timing: timing value is the clock in kHz
  // ----------------------------------------------------------------
  localparam int PROG_TIME_US = 30;
  localparam int ERASE_TIME_MS = 10;
  localparam int US_PER_MS = 1000;
  localparam logic [16:0] TICK_STEP = 17'h003e8;
  localparam logic [13:0] PROG_TICKS = 14'(PROG_TIME_US);
  localparam logic [13:0] ERASE_TICKS = 14'(ERASE_TIME_MS * US_PER_MS);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROG = 2'b01,
    OP_PERASE = 2'b10,
    OP_MERASE = 2'b11
  } fpt_op_e;
  typedef enum logic [5:0] {
    ST_LOCKED = 6'b000000,
    ST_UNLK1 = 6'b000001,
    ST_UNLK2 = 6'b000010,
    ST_UNLOCKED = 6'b000011,
    ST_SECSEL = 6'b000100,
    ST_PROG = 6'b001000,
    ST_PERASE = 6'b010000,
    ST_MERASE = 6'b100000
  } fpt_st_e;
endpackage : fpt_pkg

// [testbench/fpt_flash_prot_tb.sv]
// Self-checking bench of the flash protection and timing block
`timescale 1ns/1ps
module fpt_flash_prot_tb;
  import fpt_pkg::*;
  typedef struct packed {
    fpt_op_e op;
    logic [4:0] f;
    logic [15:0] a;
  } fpt_row_s;
  logic clk_sys_in = 1'h0;
  logic reset_in = 1'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic reg_port = 1'h0;
  logic rwp_n = 1'h1;
  logic lhp_n = 1'h1;
  logic req_valid = 1'h0;
  logic [1:0] req_op = 2'h0;
  logic req_info = 1'h0;
  logic req_port = 1'h0;
  logic [15:0] req_addr = 16'h0000;
  logic host_send = 1'h0;
  logic host_bad = 1'h0;
  logic [7:0] rdata, flash_ctl, pins, byte_v, pv;
  logic grant, refuse, bypass, clk_stop, busy, fprog, ferase, byte_valid, host_done;
  int fails = 0;
  int compares = 0;
  int n;
  // Flags: info, port, rw protect_n, lower protect_n, grant expected
  fpt_row_s rows [17] = '{
    '{OP_READ, 5'h01, 16'h0000},
    '{OP_MERASE, 5'h06, 16'h0000},
    '{OP_READ, 5'h16, 16'h00c0},
    '{OP_READ, 5'h0c, 16'h0000},
    '{OP_READ, 5'h0d, 16'h8000},
    '{OP_READ, 5'h0a, 16'h8000},
    '{OP_READ, 5'h1b, 16'h00c0},
    '{OP_PROG, 5'h1c, 16'h00c0},
    '{OP_MERASE, 5'h1e, 16'h00c0},
    '{OP_READ, 5'h06, 16'h0000},
    '{OP_PROG, 5'h0a, 16'h8000},
    '{OP_READ, 5'h0c, 16'h0000},
    '{OP_READ, 5'h0d, 16'h8000},
    '{OP_READ, 5'h0f, 16'h0000},
    '{OP_PROG, 5'h1c, 16'h00c0},
    '{OP_PERASE, 5'h1d, 16'h00c0},
    '{OP_MERASE, 5'h09, 16'h0000}
  };

  fpt_flash_prot u_fpt_flash_prot (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_from_port_in(reg_port), .reg_rdata_out(rdata),
    .whole_memory_rw_protect_in(rwp_n), .lower_half_protect_in(lhp_n),
    .req_valid_in(req_valid), .req_op_in(req_op), .req_info_in(req_info),
    .req_addr_in(req_addr), .req_from_port_in(req_port),
    .grant_out(grant), .refuse_out(refuse),
    .port_byte_valid_in(byte_valid), .port_byte_in(byte_v),
    .bypass_pins_in(pins), .flash_ctl_out(flash_ctl), .bypass_out(bypass),
    .cpu_clk_stop_out(clk_stop), .busy_out(busy),
    .flash_prog_out(fprog), .flash_erase_out(ferase)
  );
  fpt_icp_host u_fpt_icp_host (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .send_in(host_send),
    .bad_in(host_bad), .port_byte_valid_out(byte_valid), .port_byte_out(byte_v),
    .bypass_pins_out(pins), .done_out(host_done)
  );

  always #20 clk_sys_in = ~clk_sys_in;

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys_in);
    reg_wr <= 1'h0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys_in);
    reg_rd <= 1'h0;
    #1 check({8'h00, rdata}, {8'h00, exp});
  endtask : rd

  task req(input fpt_row_s r);
    @(posedge clk_sys_in);
    req_op <= r.op;
    {req_info, req_port, rwp_n, lhp_n} <= r.f[4:1];
    req_addr <= r.a;
    req_valid <= 1'h1;
    @(posedge clk_sys_in);
    req_valid <= 1'h0;
    #1 check({14'h0000, grant, refuse}, {14'h0000, r.f[0], ~r.f[0]});
  endtask : req

  task unlock(input logic [7:0] page);
    wr(ADR_CMD, 8'h00);
    wr(ADR_CMD, CMD_UNLK1);
    wr(ADR_CMD, CMD_UNLK2);
    wr(ADR_PAGE, page);
    wr(ADR_CMD, 8'h00);
  endtask : unlock

  // Waits for busy, then counts how long it stands
  task measure(input logic erase, output int len);
    int w;
    w = 0;
    len = 0;
    #1;
    while (busy !== 1'h1 && w < 4) begin
      @(posedge clk_sys_in);
      #1 w++;
    end
    check({15'h0000, erase ? ferase : fprog}, 16'h0001);
    while (busy === 1'h1 && len < 12000) begin
      @(posedge clk_sys_in);
      #1 len++;
    end
  endtask : measure

  task icp(input logic bad);
    int w;
    w = 0;
    @(posedge clk_sys_in);
    host_bad <= bad;
    host_send <= 1'h1;
    @(posedge clk_sys_in);
    host_send <= 1'h0;
    #1;
    while (host_done !== 1'h1 && w < 10) begin
      @(posedge clk_sys_in);
      #1 w++;
    end
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask : icp

  task give_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (40000) @(posedge clk_sys_in);
    fails++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge clk_sys_in);
    reset_in <= 1'h0;
    for (int i = 1; i < 6; i++) rd(8'(i), RST_BYTE);
    wr(ADR_CMD, CMD_SECSEL);
    rd(ADR_PAGE, RST_BYTE);
    wr(ADR_PAGE, RST_BYTE);
    wr(ADR_TIMH, 8'h61);
    wr(ADR_TIML, 8'ha8);
    wr(8'h05, 8'hff);
    rd(ADR_TIMH, 8'h61);
    rd(ADR_TIML, 8'ha8);
    rd(8'h05, 8'h00);
    wr(ADR_PAGE, 8'h0a);
    wr(ADR_CMD, CMD_SECSEL);
    rd(ADR_CMD, 8'h04);
    wr(ADR_PAGE, 8'h05);
    rd(ADR_PAGE, 8'h0a);
    wr(ADR_CMD, CMD_SECSEL);
    rd(ADR_PAGE, 8'h05);
    wr(ADR_PAGE, 8'h00);
    wr(ADR_CMD, CMD_SECSEL);
    rd(ADR_PAGE, 8'h05);
    unlock(8'h00);
    req('{OP_PROG, 5'h06, 16'h0000});
    unlock(8'h10);
    req('{OP_PROG, 5'h07, 16'h2000});
    measure(1'h0, n);
    check({15'h0000, n > 720 && n < 780}, 16'h0001);
    reg_port <= 1'h1;
    unlock(8'h00);
    req('{OP_PROG, 5'h0f, 16'h0000});
    measure(1'h0, n);
    reg_port <= 1'h0;
    wr(ADR_TIMH, 8'h03);
    wr(ADR_TIML, 8'he8);
    unlock(8'h10);
    wr(ADR_CMD, CMD_PERASE);
    measure(1'h1, n);
    check({15'h0000, n > 9970 && n < 10030}, 16'h0001);
    unlock(8'h10);
    req('{OP_PROG, 5'h07, 16'h2000});
    measure(1'h0, n);
    check({15'h0000, n == PROG_TIME_US}, 16'h0001);
    unlock(8'h10);
    wr(ADR_CMD, CMD_MERASE);
    rd(ADR_CMD, 8'h00);
    reg_port <= 1'h1;
    unlock(8'h00);
    wr(ADR_CMD, CMD_MERASE);
    measure(1'h1, n);
    check({15'h0000, n > 9970 && n < 10030}, 16'h0001);
    reg_port <= 1'h0;
    wr(ADR_PAGE, INFO_PAGE3);
    for (int i = 0; i < 9; i++) req(rows[i]);
    icp(1'h1);
    check({14'h0000, bypass, clk_stop}, 16'h0000);
    icp(1'h0);
    check({14'h0000, bypass, clk_stop}, 16'h0003);
    @(negedge clk_sys_in);
    pv = pins;
    @(posedge clk_sys_in);
    #1 check({8'h00, flash_ctl}, {8'h00, pv});
    for (int i = 9; i < 17; i++) req(rows[i]);
    reset_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'h0;
    #1 check({14'h0000, bypass, clk_stop}, 16'h0000);
    wr(ADR_CMD, CMD_SECSEL);
    rd(ADR_PAGE, RST_BYTE);
    give_verdict();
  end
endmodule : fpt_flash_prot_tb

// [testbench/fpt_icp_host.sv]
// Serial programming host model: bypass enable bytes and bypass pins
`timescale 1ns/1ps
module fpt_icp_host (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Commands from the bench
  input wire logic send_in,
  input wire logic bad_in,
  // Serial port bytes and bypass pins
  output logic port_byte_valid_out,
  output logic [7:0] port_byte_out,
  output logic [7:0] bypass_pins_out,
  output logic done_out
);
  logic [7:0] pins_ff = 8'h5a;

  // Wrong middle byte only when the bench asks for it
  function automatic logic [7:0] byte_at(input int i, input logic bad);
    byte_at = (i == 0) ? 8'h80 : ((i == 1) ? (8'hf0 ^ {7'h00, bad}) : 8'h04);
  endfunction : byte_at

  // Pins change every cycle so a stale sample shows
  always @(posedge clk_sys_in) begin
    pins_ff <= pins_ff + 8'h35;
  end
  assign bypass_pins_out = pins_ff;

  initial begin
    port_byte_valid_out = 1'h0;
    port_byte_out = 8'h00;
    done_out = 1'h0;
    forever begin
      @(posedge clk_sys_in);
      if (send_in === 1'h1 && reset_in === 1'h0) begin
        done_out <= 1'h0;
        for (int i = 0; i < 3; i++) begin
          port_byte_valid_out <= 1'h1;
          port_byte_out <= byte_at(i, bad_in);
          @(posedge clk_sys_in);
        end
        port_byte_valid_out <= 1'h0;
        port_byte_out <= ~port_byte_out;
        done_out <= 1'h1;
      end
    end
  end
endmodule : fpt_icp_host
